//--- hw/spi_master_slave_core.sv
// Purpose: Byte-wide full-duplex serial port, master or slave.
// Assumes: Software strobes are one-cycle pulses on i_sys_clk.
// Notes:   Pin output enables are low while the port drives the pin.
// Operation
// - Master never drives select by itself
// - Master data write shifts eight bits
// - Clock stops, done flag set after byte
// - Done flag with enable requests interrupt
// - Last received byte held until replaced
// - Deselected slave idles, MISO released, ignores SCK
// - Deselected slave accepts writes, shifts when selected
// - Slave sets done flag after full byte
// - Slave loads transmit before reading receive
// - Transmit single-buffered, write after shift only
// - Receive double-buffered, read before next completes
// - Pin directions overridden by mode
// - MOSI master to slave, MISO reverse
// - Selectable LSB-first or MSB-first order
// - Slave deselect resets logic, drops partial byte
// - Select-input low in master: becomes slave, done
// - Write during transfer flags clash; status-then-data clears
// - Done clears on vector or status-then-data access
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_core
    import spi_port_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clk_en,
    input  wire logic              i_link_sck,
    input  wire logic              i_port_enable_bit,
    input  wire logic              i_ctrl_write,
    input  wire logic              i_host_select_bit,
    input  wire logic              i_transfer_irq_enable,
    input  wire logic              i_lsb_first,
    input  wire logic              i_clock_idle_level,
    input  wire logic              i_clock_sample_edge,
    input  wire logic              i_rate_select_high,
    input  wire logic              i_rate_select_low,
    input  wire logic              i_double_rate_bit,
    input  wire logic              i_mosi_dir_out,
    input  wire logic              i_miso_dir_out,
    input  wire logic              i_sck_dir_out,
    input  wire logic              i_ss_dir_out,
    input  wire logic              i_ss_out_level,
    input  wire logic              i_data_write,
    input  wire logic [DATA_W-1:0] i_data_wdata,
    input  wire logic              i_data_read,
    input  wire logic              i_status_read,
    input  wire logic              i_irq_ack,
    input  wire logic              i_mosi,
    input  wire logic              i_miso,
    input  wire logic              i_ss_n,
    output logic                   o_mosi,
    output logic                   o_mosi_oe_n,
    output logic                   o_miso,
    output logic                   o_miso_oe_n,
    output logic                   o_sck,
    output logic                   o_sck_oe_n,
    output logic                   o_ss_n,
    output logic                   o_ss_oe_n,
    output logic [DATA_W-1:0]      o_rx_data,
    output logic                   o_transfer_done_flag,
    output logic                   o_write_clash_flag,
    output logic                   o_host_select_bit,
    output logic                   o_irq
);

    master_state_t      state,       next_state;
    logic [HALF_W-1:0]  div_cnt,     next_div_cnt;
    logic [3:0]         edge_cnt,    next_edge_cnt;
    logic [DATA_W-1:0]  sh,          next_sh;
    logic [DATA_W-1:0]  tx_byte,     next_tx_byte;
    logic [DATA_W-1:0]  rx_data,     next_rx_data;
    logic               sck_q,       next_sck_q;
    logic               mosi_q,      next_mosi_q;
    logic               done_flag,   next_done_flag;
    logic               clash_flag,  next_clash_flag;
    logic               arm_done,    next_arm_done;
    logic               arm_clash,   next_arm_clash;
    logic               host_sel,    next_host_sel;
    logic               irq_q,       next_irq_q;
    logic               slave_en,    next_slave_en;
    logic               mosi_oe_n,   next_mosi_oe_n;
    logic               miso_oe_n,   next_miso_oe_n;
    logic               sck_oe_n,    next_sck_oe_n;
    logic               ss_oe_n,     next_ss_oe_n;
    logic               ss_out,      next_ss_out;
    logic               done_seen,   next_done_seen;
    logic [2:0]         sync_meta;
    logic [2:0]         sync_q;
    logic               miso_s;
    logic               ss_low;
    logic               toggle_s;
    logic               link_rst_n;
    logic               link_miso;
    logic               link_toggle;
    logic [DATA_W-1:0]  link_rx;
    logic [HALF_W-1:0]  half_cnt;
    logic               master_on;
    logic               busy;
    logic               tick;
    logic               sample_edge;

    // Select pin resets the slave shifter at once, without waiting for a clock
    assign link_rst_n = i_rst_n & slave_en & ~i_ss_n;

    spi_link_slave #(
        .DW (DATA_W)
    ) u_link (
        .i_link_sck          (i_link_sck),
        .i_link_rst_n        (link_rst_n),
        .i_rst_n             (i_rst_n),
        .i_clock_idle_level  (i_clock_idle_level),
        .i_clock_sample_edge (i_clock_sample_edge),
        .i_lsb_first         (i_lsb_first),
        .i_mosi              (i_mosi),
        .i_tx_byte           (tx_byte),
        .o_miso_bit          (link_miso),
        .o_rx_byte           (link_rx),
        .o_done_toggle       (link_toggle)
    );

    // Two-stage synchronisers: master MISO, select pin, slave done toggle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_meta <= 3'h6;
            sync_q    <= 3'h6;
        end else if (i_clk_en) begin
            sync_meta <= {i_ss_n, i_miso, link_toggle};
            sync_q    <= sync_meta;
        end
    end

    assign ss_low   = ~sync_q[2];
    assign miso_s   = sync_q[1];
    assign toggle_s = sync_q[0];

    function automatic logic [HALF_W-1:0] half_of(input logic dbl, input logic [1:0] sel);
        logic [HALF_W-1:0] h;
        h = HALF_DIV4;
        unique case ({dbl, sel})
            3'h0: h = HALF_DIV4;
            3'h1: h = HALF_DIV16;
            3'h2: h = HALF_DIV64;
            3'h3: h = HALF_DIV128;
            3'h4: h = HALF_DIV2;
            3'h5: h = HALF_DIV8;
            3'h6: h = HALF_DIV32;
            3'h7: h = HALF_DIV64;
        endcase
        return h;
    endfunction : half_of

    function automatic logic out_bit(input logic lsb, input logic [DATA_W-1:0] d);
        return lsb ? d[0] : d[DATA_W-1];
    endfunction : out_bit

    assign half_cnt    = half_of(i_double_rate_bit, {i_rate_select_high, i_rate_select_low});
    assign master_on   = i_port_enable_bit & host_sel;
    assign busy        = master_on ? (state == M_SHIFT) : (i_port_enable_bit & ss_low);
    assign tick        = (state == M_SHIFT) && (div_cnt == half_cnt - 7'h01);
    assign sample_edge = (edge_cnt[0] == i_clock_sample_edge);

    always_comb begin
        logic set_done;
        set_done        = 1'b0;
        next_state      = state;
        next_div_cnt    = div_cnt;
        next_edge_cnt   = edge_cnt;
        next_sh         = sh;
        next_tx_byte    = tx_byte;
        next_rx_data    = rx_data;
        next_sck_q      = sck_q;
        next_mosi_q     = mosi_q;
        next_host_sel   = host_sel;
        next_done_seen  = toggle_s;
        next_slave_en   = i_port_enable_bit & ~host_sel;
        next_ss_out     = i_ss_out_level;
        next_done_flag  = done_flag;
        next_clash_flag = clash_flag;
        next_arm_done   = arm_done;
        next_arm_clash  = arm_clash;

        if (i_ctrl_write) begin
            next_host_sel = i_host_select_bit;
        end

        if (state == M_IDLE) begin
            next_sck_q = i_clock_idle_level;
        end else begin
            next_div_cnt = div_cnt + 7'h01;
            if (tick) begin
                next_div_cnt  = 7'h00;
                next_sck_q    = ~sck_q;
                next_edge_cnt = edge_cnt + 4'h1;
                if (sample_edge) begin
                    next_sh = i_lsb_first ? {miso_s, sh[DATA_W-1:1]} : {sh[DATA_W-2:0], miso_s};
                end else begin
                    next_mosi_q = out_bit(i_lsb_first, sh);
                end
                if (edge_cnt == EDGE_LAST) begin
                    next_state   = M_IDLE;
                    next_rx_data = next_sh;
                    set_done     = 1'b1;
                end
            end
        end

        // A finished slave byte is taken as a word once its toggle has settled
        if (toggle_s != done_seen) begin
            next_rx_data = link_rx;
            set_done     = 1'b1;
        end

        if (i_data_write) begin
            if (busy) begin
                next_clash_flag = 1'b1;
            end else begin
                next_tx_byte = i_data_wdata;
                if (master_on) begin
                    next_state    = M_SHIFT;
                    next_sh       = i_data_wdata;
                    next_div_cnt  = 7'h00;
                    next_edge_cnt = 4'h0;
                    next_mosi_q   = out_bit(i_lsb_first, i_data_wdata);
                end
            end
        end

        // Another master pulled our select input low
        if (master_on && !i_ss_dir_out && ss_low) begin
            next_host_sel = 1'b0;
            next_state    = M_IDLE;
            set_done      = 1'b1;
        end

        if (i_data_read || i_data_write) begin
            if (arm_done || arm_clash) begin
                next_done_flag = 1'b0;
            end
            if (arm_clash) begin
                next_clash_flag = 1'b0;
            end
            next_arm_done  = 1'b0;
            next_arm_clash = 1'b0;
        end
        if (i_irq_ack) begin
            next_done_flag = 1'b0;
        end
        if (i_status_read) begin
            next_arm_done  = done_flag;
            next_arm_clash = clash_flag;
        end
        // Hardware set wins over any clear in the same cycle
        if (set_done) begin
            next_done_flag = 1'b1;
        end
        if (i_data_write && busy) begin
            next_clash_flag = 1'b1;
        end

        next_irq_q     = next_done_flag & i_transfer_irq_enable;
        next_mosi_oe_n = ~(master_on & i_mosi_dir_out);
        next_sck_oe_n  = ~(master_on & i_sck_dir_out);
        next_ss_oe_n   = ~(master_on & i_ss_dir_out);
        next_miso_oe_n = ~(i_port_enable_bit & ~host_sel & ss_low & i_miso_dir_out);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state      <= M_IDLE;
            div_cnt    <= 7'h00;
            edge_cnt   <= 4'h0;
            sh         <= DATA_RESET;
            tx_byte    <= DATA_RESET;
            rx_data    <= DATA_RESET;
            sck_q      <= 1'b0;
            mosi_q     <= 1'b0;
            done_flag  <= 1'b0;
            clash_flag <= 1'b0;
            arm_done   <= 1'b0;
            arm_clash  <= 1'b0;
            host_sel   <= 1'b0;
            irq_q      <= 1'b0;
            slave_en   <= 1'b0;
            done_seen  <= 1'b0;
            mosi_oe_n  <= 1'b1;
            miso_oe_n  <= 1'b1;
            sck_oe_n   <= 1'b1;
            ss_oe_n    <= 1'b1;
            ss_out     <= 1'b1;
        end else if (i_clk_en) begin
            state      <= next_state;
            div_cnt    <= next_div_cnt;
            edge_cnt   <= next_edge_cnt;
            sh         <= next_sh;
            tx_byte    <= next_tx_byte;
            rx_data    <= next_rx_data;
            sck_q      <= next_sck_q;
            mosi_q     <= next_mosi_q;
            done_flag  <= next_done_flag;
            clash_flag <= next_clash_flag;
            arm_done   <= next_arm_done;
            arm_clash  <= next_arm_clash;
            host_sel   <= next_host_sel;
            irq_q      <= next_irq_q;
            slave_en   <= next_slave_en;
            done_seen  <= next_done_seen;
            mosi_oe_n  <= next_mosi_oe_n;
            miso_oe_n  <= next_miso_oe_n;
            sck_oe_n   <= next_sck_oe_n;
            ss_oe_n    <= next_ss_oe_n;
            ss_out     <= next_ss_out;
        end
    end

    // MISO follows the slave shifter directly so with leading-edge sampling the first bit is ready before any edge
    assign o_miso               = link_miso;
    assign o_mosi               = mosi_q;
    assign o_mosi_oe_n          = mosi_oe_n;
    assign o_miso_oe_n          = miso_oe_n;
    assign o_sck                = sck_q;
    assign o_sck_oe_n           = sck_oe_n;
    assign o_ss_n               = ss_out;
    assign o_ss_oe_n            = ss_oe_n;
    assign o_rx_data            = rx_data;
    assign o_transfer_done_flag = done_flag;
    assign o_write_clash_flag   = clash_flag;
    assign o_host_select_bit    = host_sel;
    assign o_irq                = irq_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    logic set_done_any;
    assign set_done_any = (toggle_s != done_seen) || (tick && edge_cnt == EDGE_LAST)
                          || (master_on && !i_ss_dir_out && ss_low);

    sequence s_status_seen;
        i_clk_en && i_status_read && done_flag && !set_done_any;
    endsequence
    sequence s_data_access;
        i_clk_en && (i_data_read || i_data_write) && !set_done_any && !i_status_read;
    endsequence

    a_master_start: assert property (i_clk_en && master_on && state == M_IDLE && i_data_write && !(!i_ss_dir_out && ss_low)
        |=> state == M_SHIFT && edge_cnt == 4'h0) else $error("master write did not start a byte");
    a_byte_stop: assert property (i_clk_en && tick && edge_cnt == EDGE_LAST
        |=> state == M_IDLE && done_flag) else $error("byte end did not stop clock and flag");
    a_irq_follow: assert property (i_clk_en && next_done_flag && i_transfer_irq_enable |=> o_irq)
        else $error("done flag with enable gave no interrupt");
    a_rx_hold: assert property (i_clk_en && !set_done_any |=> $stable(o_rx_data))
        else $error("receive buffer changed without a new byte");
    a_miso_release: assert property (i_clk_en && !ss_low |=> o_miso_oe_n)
        else $error("MISO driven while deselected");
    a_slave_load: assert property (i_clk_en && !host_sel && !ss_low && i_data_write
        |=> tx_byte == $past(i_data_wdata)) else $error("deselected slave refused data");
    a_slave_done: assert property (i_clk_en && toggle_s != done_seen |=> done_flag && o_rx_data == $past(link_rx))
        else $error("slave byte did not set done flag");
    a_clash_set: assert property (i_clk_en && busy && i_data_write |=> clash_flag && $stable(tx_byte))
        else $error("write during transfer not flagged");
    a_mode_fault: assert property (i_clk_en && master_on && !i_ss_dir_out && ss_low
        |=> !host_sel && done_flag && state == M_IDLE) else $error("select fault not handled");
    a_flag_clear: assert property (s_status_seen ##1 s_data_access
        |=> !done_flag) else $error("status then data access did not clear");
    a_sck_idle: assert property (i_clk_en && state == M_IDLE ##1 i_clk_en && state == M_IDLE && $stable(i_clock_idle_level)
        |=> o_sck == i_clock_idle_level) else $error("SCK idle level wrong");
    a_pin_force: assert property (master_on ##1 master_on |=> o_miso_oe_n)
        else $error("MISO not input in master mode");

endmodule : spi_master_slave_core
`default_nettype wire

//--- hw/spi_port_pkg.sv
// Purpose: Shared constants and types for the byte-wide serial port.
// Assumes: System clock 10 MHz; bit rate counts are in system clock cycles.
// Notes:   Half-period counts are half of the documented divide ratios.
package spi_port_pkg;

    localparam int unsigned DATA_W         = 8;
    localparam int unsigned BIT_CNT        = 8;
    localparam int unsigned EDGE_CNT       = 2 * BIT_CNT;
    localparam int unsigned HALF_W         = 7;
    // Least SCK phase, in system cycles, that the slave sampler tolerates
    localparam int unsigned SLAVE_PHASE_MIN_CYC = 2;

    // Half SCK periods for rate select 00..11, normal and double rate
    localparam logic [HALF_W-1:0] HALF_DIV4   = 7'h02;
    localparam logic [HALF_W-1:0] HALF_DIV16  = 7'h08;
    localparam logic [HALF_W-1:0] HALF_DIV64  = 7'h20;
    localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;
    localparam logic [HALF_W-1:0] HALF_DIV2   = 7'h01;
    localparam logic [HALF_W-1:0] HALF_DIV8   = 7'h04;
    localparam logic [HALF_W-1:0] HALF_DIV32  = 7'h10;

    localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
    localparam logic [3:0]        EDGE_LAST   = 4'hF;

    typedef enum logic {
        M_IDLE,
        M_SHIFT
    } master_state_t;

endpackage : spi_port_pkg

//--- hw/spi_link_slave.sv
// Purpose: Slave-mode shifter clocked directly by the incoming serial clock.
// Assumes: Mode bits and transmit byte are held steady while selected.
// Notes:   Shift state held in reset while select is high or the port is not a slave; finished byte kept.
`timescale 1ns/1ns
`default_nettype none
module spi_link_slave
    import spi_port_pkg::*;
#(
    parameter int unsigned DW = DATA_W
) (
    input  wire logic          i_link_sck,
    input  wire logic          i_link_rst_n,
    input  wire logic          i_rst_n,
    input  wire logic          i_clock_idle_level,
    input  wire logic          i_clock_sample_edge,
    input  wire logic          i_lsb_first,
    input  wire logic          i_mosi,
    input  wire logic [DW-1:0] i_tx_byte,
    output logic               o_miso_bit,
    output logic [DW-1:0]      o_rx_byte,
    output logic               o_done_toggle
);

    // Sampling always lands on the rising edge of this folded clock
    logic           eff_clk;
    logic [DW-1:0]  rx_sh;
    logic [DW-1:0]  next_rx_sh;
    logic [2:0]     in_cnt;
    logic [2:0]     next_in_cnt;
    logic [2:0]     out_cnt;
    logic [2:0]     next_out_cnt;
    logic [2:0]     out_idx;
    logic [DW-1:0]  rx_byte;
    logic [DW-1:0]  next_rx_byte;
    logic           done_toggle;
    logic           next_done_toggle;

    assign eff_clk = i_link_sck ^ i_clock_idle_level ^ i_clock_sample_edge;

    always_comb begin
        next_rx_sh       = i_lsb_first ? {i_mosi, rx_sh[DW-1:1]} : {rx_sh[DW-2:0], i_mosi};
        next_in_cnt      = in_cnt + 3'h1;
        next_rx_byte     = rx_byte;
        next_done_toggle = done_toggle;
        if (in_cnt == 3'h7) begin
            next_rx_byte     = next_rx_sh;
            next_done_toggle = ~done_toggle;
        end
    end

    // Partial bytes vanish with the select-driven reset
    always_ff @(posedge eff_clk or negedge i_link_rst_n) begin
        if (!i_link_rst_n) begin
            rx_sh  <= DATA_RESET;
            in_cnt <= 3'h0;
        end else begin
            rx_sh  <= next_rx_sh;
            in_cnt <= next_in_cnt;
        end
    end

    // Finished byte and its event survive the deselect reset
    always_ff @(posedge eff_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_byte     <= DATA_RESET;
            done_toggle <= 1'b0;
        end else begin
            rx_byte     <= next_rx_byte;
            done_toggle <= next_done_toggle;
        end
    end

    always_comb begin
        next_out_cnt = out_cnt + 3'h1;
    end

    always_ff @(negedge eff_clk or negedge i_link_rst_n) begin
        if (!i_link_rst_n) begin
            out_cnt <= 3'h0;
        end else begin
            out_cnt <= next_out_cnt;
        end
    end

    // With trailing-edge sampling the first setup edge advances the count once
    assign out_idx       = i_clock_sample_edge ? out_cnt - 3'h1 : out_cnt;
    assign o_miso_bit    = i_lsb_first ? i_tx_byte[out_idx] : i_tx_byte[3'h7 - out_idx];
    assign o_rx_byte     = rx_byte;
    assign o_done_toggle = done_toggle;

endmodule : spi_link_slave
`default_nettype wire

//--- bench/spi_far_slave.sv
// Purpose: Far-side peripheral for master-mode tests, SPI mode 0, MSB first.
// Assumes: Select and clock come from the port under test.
// Notes:   Released MISO shows the inverse of its first bit, never a stale copy.
`timescale 1ns/1ns
`default_nettype none
module spi_far_slave #(
    parameter logic [7:0] TX_BYTE = 8'h3C
) (
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    // One process owns the falling-edge count; deselect restarts the byte
    logic [3:0] n_fall = 4'h0;
    logic [7:0] tx;
    assign tx     = TX_BYTE << n_fall;
    assign o_miso = i_ss_n ? ~tx[7] : tx[7];
    always @(negedge i_sck or posedge i_ss_n) begin
        if (i_ss_n) n_fall = 4'h0;
        else n_fall = n_fall + 4'h1;
    end
    always @(posedge i_sck) if (!i_ss_n) o_rx = {o_rx[6:0], i_mosi};
endmodule : spi_far_slave
`default_nettype wire

//--- bench/testbench.sv
// Purpose: Self-checking bench for the serial port, master and slave.
// Assumes: Mode 0, MSB first, rate code 01 (half period 8 cycles).
// Notes:   Slave SCK is kept slow; the slave shifter is clocked by SCK directly, not oversampled.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import spi_port_pkg::*;
    logic       clk = 0, rst_n = 0, cw = 0, hs = 1, dw = 0, dr = 0, sr = 0;
    logic       ssi = 1, bsck = 0, bmosi = 0, ssdir = 1, ack = 0;
    logic       cen = 1, pen = 1, ien = 1, lsb = 0, clock_idle_level = 0, clock_sample_edge = 0, rsh = 0, rsl = 1, dbl = 0;
    logic       mdir = 1, midir = 1, skdir = 1, ssl = 0;
    logic [7:0] wd = 8'h00;
    wire logic [7:0] rx, frx;
    wire logic  mo, mo_oe, mi, mi_oe, sk, sk_oe, so, so_oe, done, clash, hsel, irq, fmiso;
    wire logic  sck_pin = sk_oe ? bsck : sk;
    wire logic  mosi_pin = mo_oe ? bmosi : mo;
    wire logic  miso_pin = mi_oe ? fmiso : mi;
    int         n_mismatch = 0, num_checks = 0;
    spi_master_slave_core i_spi_master_slave_core (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(cen),
        .i_link_sck(sck_pin), .i_port_enable_bit(pen), .i_ctrl_write(cw), .i_host_select_bit(hs),
        .i_transfer_irq_enable(ien), .i_lsb_first(lsb), .i_clock_idle_level(clock_idle_level),
        .i_clock_sample_edge(clock_sample_edge), .i_rate_select_high(rsh), .i_rate_select_low(rsl),
        .i_double_rate_bit(dbl), .i_mosi_dir_out(mdir), .i_miso_dir_out(midir), .i_sck_dir_out(skdir),
        .i_ss_dir_out(ssdir), .i_ss_out_level(ssl), .i_data_write(dw), .i_data_wdata(wd),
        .i_data_read(dr), .i_status_read(sr), .i_irq_ack(ack), .i_mosi(mosi_pin), .i_miso(miso_pin),
        .i_ss_n(ssi), .o_mosi(mo), .o_mosi_oe_n(mo_oe), .o_miso(mi), .o_miso_oe_n(mi_oe), .o_sck(sk),
        .o_sck_oe_n(sk_oe), .o_ss_n(so), .o_ss_oe_n(so_oe), .o_rx_data(rx), .o_transfer_done_flag(done),
        .o_write_clash_flag(clash), .o_host_select_bit(hsel), .o_irq(irq));
    spi_far_slave i_spi_far_slave (.i_sck(sck_pin), .i_mosi(mosi_pin), .i_ss_n(so_oe ? 1'b1 : so),
        .o_miso(fmiso), .o_rx(frx));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1;
        @(negedge clk) s = 0;
    endtask : pulse
    task automatic wait_done;
        int i;
        for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
        chk("done", 8'h01, {7'h00, done});
    endtask : wait_done
    task automatic master_byte;
        wd = 8'hA5;
        pulse(dw);
        wait_done();
        chk("far rx", 8'hA5, frx);
        chk("rx", 8'h3C, rx);
        chk("irq", 8'h01, {7'h00, irq});
        chk("sck idle", 8'h00, {7'h00, sk});
        chk("ss held", 8'h00, {7'h00, so});
        pulse(sr);
        pulse(dr);
        chk("done cleared", 8'h00, {7'h00, done});
    endtask : master_byte
    task automatic clash_then_clear;
        wd = 8'h11;
        pulse(dw);
        repeat (10) @(negedge clk);
        wd = 8'h22;
        pulse(dw);
        chk("clash", 8'h01, {7'h00, clash});
        wait_done();
        chk("far rx kept", 8'h11, frx);
        pulse(sr);
        pulse(dr);
        chk("flags cleared", 8'h00, {6'h00, clash, done});
    endtask : clash_then_clear
    task automatic master_lsb_fast;
        ssl = 1;
        repeat (2) @(negedge clk);
        chk("ss follows", 8'h01, {7'h00, so});
        ssl = 0;
        lsb = 1;
        dbl = 1;
        ien = 0;
        repeat (2) @(negedge clk);
        wd = 8'h01;
        pulse(dw);
        wait_done();
        chk("far rx lsb", 8'h80, frx);
        chk("rx lsb", 8'h3C, rx);
        chk("irq off", 8'h00, {7'h00, irq});
        pulse(sr);
        pulse(dr);
        lsb = 0;
        dbl = 0;
        ien = 1;
    endtask : master_lsb_fast
    task automatic slave_byte;
        logic [7:0] got;
        logic [7:0] pat;
        pat = 8'hC3;
        got = 8'h00;
        hs = 0;
        pulse(cw);
        repeat (3) @(negedge clk);
        chk("miso released", 8'h01, {7'h00, mi_oe});
        wd = 8'h96;
        pulse(dw);
        ssi = 0;
        for (int b = 7; b >= 0; b--) begin
            bmosi = pat[b];
            repeat (4) @(negedge clk);
            got[b] = miso_pin;
            bsck = 1;
            repeat (4) @(negedge clk);
            bsck = 0;
        end
        chk("miso driven", 8'h00, {7'h00, mi_oe});
        wait_done();
        chk("slave rx", 8'hC3, rx);
        chk("slave tx", 8'h96, got);
        ssi = 1;
        repeat (3) @(negedge clk);
        wd = 8'h5A;
        pulse(dw);
        chk("no clash", 8'h00, {7'h00, clash});
        chk("rx kept", 8'hC3, rx);
        chk("tx loaded", 8'h00, {7'h00, mi});
        pulse(sr);
        pulse(dr);
        chk("slave done cleared", 8'h00, {7'h00, done});
    endtask : slave_byte
    task automatic ss_abort;
        hs = 1;
        ssdir = 0;
        pulse(cw);
        @(negedge clk) ssi = 0;
        repeat (6) @(negedge clk);
        chk("host sel", 8'h00, {7'h00, hsel});
        chk("done", 8'h01, {7'h00, done});
    endtask : ss_abort
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        pulse(cw);
        repeat (4) @(negedge clk);
        master_byte();
        clash_then_clear();
        master_lsb_fast();
        slave_byte();
        ss_abort();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
